/* File: src/badc_pkg.sv */
// Purpose: shared constants of the bridge converter control block
// Assumes: 250 MHz system clock, 1.024 MHz converter clock
// Notes: register addresses are the 3-bit serial-port addresses
package badc_pkg;
  // register addresses
  localparam logic [2:0] ADDR_STATUS = 3'h0;
  localparam logic [2:0] ADDR_MODE = 3'h1;
  localparam logic [2:0] ADDR_CONFIG = 3'h2;
  localparam logic [2:0] ADDR_DATA = 3'h3;
  localparam logic [2:0] ADDR_ID = 3'h4;
  localparam logic [2:0] ADDR_OFFSET = 3'h6;
  localparam logic [2:0] ADDR_GAIN = 3'h7;
  // mode register fields
  localparam int MD_HI = 15;
  localparam int MD_LO = 13;
  localparam int CLK_HI = 7;
  localparam int CLK_LO = 6;
  localparam int CHOP_BIT = 4;
  localparam int RATE_HI = 3;
  localparam int RATE_LO = 0;
  localparam logic [15:0] MODE_RST = 16'h000a;
  // configuration register fields
  localparam int CFG_BURNOUT_SRC_EN = 13;
  localparam int CFG_FMT = 12;
  localparam int CFG_REF_DETECT_EN = 5;
  localparam int CH_HI = 2;
  localparam int CH_LO = 0;
  localparam logic [15:0] CFG_RST = 16'h0710;
  // status register fields
  localparam int ST_RDY = 7;
  localparam int ST_ERR = 6;
  localparam int ST_MISSING_REF_FLAG = 5;
  localparam int ST_ZERO = 4;
  localparam int ST_WIDE = 3;
  localparam logic [2:0] TAG_RST = 3'h0;
  // operating mode codes
  localparam logic [2:0] MD_CONT = 3'h0;
  localparam logic [2:0] MD_SINGLE = 3'h1;
  localparam logic [2:0] MD_IDLE = 3'h2;
  localparam logic [2:0] MD_SLEEP = 3'h3;
  // channel codes
  localparam logic [2:0] CH_PAIR1 = 3'h0;
  localparam logic [2:0] CH_PAIR2 = 3'h1;
  localparam logic [2:0] CH_SHORT = 3'h3;
  localparam logic [2:0] CH_TEMP = 3'h6;
  localparam logic [2:0] CH_SUPPLY = 3'h7;
  // clock select codes
  localparam logic [1:0] CLKSEL_INT = 2'h0;
  localparam logic [1:0] CLKSEL_INT_OUT = 2'h1;
  // coefficient and data reset values, full width
  localparam logic [23:0] OFFSET_RST = 24'h800000;
  localparam logic [23:0] GAIN_RST = 24'h555555;
  localparam logic [23:0] DATA_RST = 24'h000000;
  // identity nibble is arbitrary; low bits carry the fixed pattern
  localparam logic [3:0] ID_UPPER = 4'h6;
  localparam logic [2:0] ID_FIXED = 3'h5;
  // timing
  localparam int SYS_FREQ_KHZ = 250000;
  localparam int OSC_FREQ_KHZ = 1024;
  localparam int OSC_DIV = SYS_FREQ_KHZ / OSC_FREQ_KHZ;
  localparam int TICK_W = 19;
  localparam int CHOP_SETTLE_SHIFT = 1;

  // converter-clock ticks per result for each rate code
  function automatic logic [TICK_W-1:0] rate_ticks(input logic [3:0] code);
    case (code)
      4'h0: rate_ticks = 19'd1151;
      4'h1: rate_ticks = 19'd2179;
      4'h2: rate_ticks = 19'd4231;
      4'h3: rate_ticks = 19'd8325;
      4'h4: rate_ticks = 19'd16516;
      4'h5: rate_ticks = 19'd20480;
      4'h6: rate_ticks = 19'd26256;
      4'h7: rate_ticks = 19'd30843;
      4'h8: rate_ticks = 19'd52245;
      4'h9: rate_ticks = 19'd61317;
      4'ha: rate_ticks = 19'd61317;
      4'hb: rate_ticks = 19'd81920;
      4'hc: rate_ticks = 19'd102400;
      4'hd: rate_ticks = 19'd122929;
      4'he: rate_ticks = 19'd163840;
      default: rate_ticks = 19'd245563;
    endcase
  endfunction
endpackage

/* File: src/badc_tick_gen.sv */
// Purpose: converter clock source, one-cycle tick per converter clock
// Assumes: external clock pin is asynchronous to clk_sys
// Notes: internal oscillator is a divider of clk_sys
`timescale 1ns/100ps
module badc_tick_gen import badc_pkg::*; #(
  parameter int DIV = OSC_DIV
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic use_ext,
  input wire logic ext_clk,
  output logic osc_level,
  output logic sys_tick
);
  logic [15:0] div_cnt;
  logic ext_meta;
  logic ext_sync;
  logic ext_prev;
  logic osc_rise;

  // half-period toggling builds a square internal clock
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 16'h0000;
      osc_level <= 1'b0;
    end else if (div_cnt == 16'(DIV / 2 - 1)) begin
      div_cnt <= 16'h0000;
      osc_level <= ~osc_level;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end

  assign osc_rise = (div_cnt == 16'(DIV / 2 - 1)) && !osc_level;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      ext_meta <= ext_clk;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sys_tick <= 1'b0;
    end else begin
      sys_tick <= use_ext ? (ext_sync && !ext_prev) : osc_rise;
    end
  end
endmodule

/* File: src/badc_regs.sv */
// Purpose: mode, configuration, result and coefficient registers with
//   the conversion sequencer of a two-channel bridge converter
// Assumes: serial front end delivers decoded register accesses on clk_sys;
//   modulator result and range flags are on clk_sys
// Notes: filter and calibration arithmetic live outside; measured values
//   arrive on conv_value
`timescale 1ns/100ps
// Summary of operation
// - mode field bits 15:13 picks continuous, single, idle or sleep; resets continuous
// - single mode restarts the filter, converts once, then enters sleep
// - idle holds the filter in reset while the modulator keeps running
// - sleep powers down most circuitry and produces no conversions
// - mode codes 100 to 111 start the four calibration kinds
// - ready output goes high at calibration start, then follows the status ready bit again when it completes
// - a finished calibration drops the device into idle on its own
// - calibration result lands in the selected channel's offset or gain register
// - clock-select bits 7:6 pick internal, internal driven out, or external clock
// - chopping doubles settling: first result takes twice the normal time
// - rate bits 3:0 pick the output rate; reset code 1010
// - configuration bit 13 enables the burnout current sources
// - configuration bit 12 picks bipolar or unipolar coding
// - bit 5 enables reference detection; only then missing-reference flag reports
// - channel bits 2:0 pick pair 1, pair 2, shorted, temperature or supply
// - internal channels force unity gain and internal reference; supply divided
// - each result carries its channel code in the status tag field
// - status bit 3 shows the wide variant; status bit 4 reads zero
// - data register holds each result in two's complement, reset zero
// - coefficients always readable, writable only in idle or sleep
// - offset coefficients reset to midscale
// - gain coefficients reset to the alternating-bit default
// - two coefficient pairs; shorted shares pair 0; internal channels use defaults
// - ready bit clears on a new result and sets after the data is read
// - error bit updates with each result from range or reference faults
// - low reference with detection on sets the flag and clamps results to ones
// - registers are reached by 3-bit addressed read and write commands
module badc_regs import badc_pkg::*; #(
  parameter int DATA_W = 24,
  parameter int TICK_DIV = OSC_DIV
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [2:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [23:0] reg_wdata,
  input wire logic reg_rd,
  output logic [23:0] reg_rdata,
  input wire logic [DATA_W-1:0] conv_value,
  input wire logic conv_overrange,
  input wire logic conv_underrange,
  input wire logic ref_low,
  input wire logic clk_pin_i,
  output logic clk_pin_o,
  output logic clk_pin_oe_n,
  output logic system_clock_tick,
  output logic result_ready_n,
  output logic filter_reset,
  output logic sleep_powerdown,
  output logic chop_active,
  output logic [3:0] rate_code,
  output logic burnout_src_en,
  output logic format_unipolar,
  output logic ref_detect_en,
  output logic [2:0] input_select,
  output logic force_unity_gain,
  output logic use_internal_ref,
  output logic supply_div6_en,
  output logic cal_system,
  output logic cal_full_scale
);
  localparam logic [23:0] DMASK = 24'hffffff >> (24 - DATA_W);
  localparam logic [23:0] OFS_DEF = OFFSET_RST >> (24 - DATA_W);
  localparam logic [23:0] GAIN_DEF = GAIN_RST >> (24 - DATA_W);

  typedef enum logic [1:0] {SEQ_HOLD, SEQ_RUN, SEQ_CAL} badc_seq_e;

  logic [15:0] mode_reg;
  logic [15:0] cfg_reg;
  logic [23:0] result;
  logic status_rdy_n;
  logic status_err;
  logic [2:0] result_channel_tag;
  logic [23:0] ofs_coef [2];
  logic [23:0] gain_coef [2];
  badc_seq_e seq;
  logic [TICK_W-1:0] conv_cnt;
  logic first_result;
  logic ref_meta;
  logic ref_sync;
  logic tick;
  logic [2:0] op_mode_sel;
  logic [1:0] clk_sel;
  logic chop_disable;
  logic missing_ref_flag;
  logic [TICK_W-1:0] conv_target;
  logic conv_done;
  logic mode_wr;
  logic cfg_wr;
  logic coef_wr_ok;
  logic [1:0] sel_pair;
  logic [7:0] status_byte;
  logic [23:0] clamped;
  logic [23:0] next_rdata;
  badc_seq_e next_seq;
  logic cal_store;
  logic result_store;
  logic coef_host_wr;

  // maps a channel code to its coefficient pair; bit 1 marks a valid pair
  function automatic logic [1:0] pair_of(input logic [2:0] ch);
    case (ch)
      CH_PAIR1: pair_of = 2'b10;
      CH_SHORT: pair_of = 2'b10;
      CH_PAIR2: pair_of = 2'b11;
      default: pair_of = 2'b00;
    endcase
  endfunction

  assign op_mode_sel = mode_reg[MD_HI:MD_LO];
  assign clk_sel = mode_reg[CLK_HI:CLK_LO];
  assign chop_disable = mode_reg[CHOP_BIT];
  assign rate_code = mode_reg[RATE_HI:RATE_LO];
  assign burnout_src_en = cfg_reg[CFG_BURNOUT_SRC_EN];
  assign format_unipolar = cfg_reg[CFG_FMT];
  assign ref_detect_en = cfg_reg[CFG_REF_DETECT_EN];
  assign input_select = cfg_reg[CH_HI:CH_LO];
  assign sel_pair = pair_of(input_select);
  assign mode_wr = reg_wr && (reg_addr == ADDR_MODE);
  assign cfg_wr = reg_wr && (reg_addr == ADDR_CONFIG);
  // host coefficient writes are refused while the filter may be using them
  assign coef_wr_ok = (op_mode_sel == MD_IDLE) || (op_mode_sel == MD_SLEEP);

  // internal channels override gain and reference settings
  assign force_unity_gain = (input_select == CH_TEMP) || (input_select == CH_SUPPLY);
  assign use_internal_ref = force_unity_gain;
  assign supply_div6_en = (input_select == CH_SUPPLY);

  // clock pin: driven only when the internal clock is routed out
  assign clk_pin_oe_n = (clk_sel != CLKSEL_INT_OUT);
  assign system_clock_tick = tick;

  badc_tick_gen #(
    .DIV(TICK_DIV)
  ) u_tick (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .use_ext(clk_sel[1]),
    .ext_clk(clk_pin_i),
    .osc_level(clk_pin_o),
    .sys_tick(tick)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ref_meta <= 1'b0;
      ref_sync <= 1'b0;
    end else begin
      ref_meta <= ref_low;
      ref_sync <= ref_meta;
    end
  end

  assign missing_ref_flag = ref_detect_en && ref_sync;

  // a missing reference overrides whatever the filter produced
  always_comb begin
    clamped = 24'(conv_value) & DMASK;
    if (missing_ref_flag) begin
      clamped = DMASK;
    end
  end

  // chopping doubles the time to the first settled result; the rate code
  // is an argument so the target follows every mode write
  always_comb begin
    conv_target = rate_ticks(rate_code);
    if (first_result && !chop_disable) begin
      conv_target = conv_target << CHOP_SETTLE_SHIFT;
    end
  end
  assign conv_done = (seq != SEQ_HOLD) && tick && (conv_cnt + 19'd1 >= conv_target);
  // completion qualified by what the sequencer was doing
  assign cal_store = conv_done && (seq == SEQ_CAL);
  assign result_store = conv_done && (seq == SEQ_RUN);
  assign coef_host_wr = reg_wr && coef_wr_ok;

  // sequencer: a mode write restarts the filter and outranks a completion
  always_comb begin
    next_seq = seq;
    if (mode_wr) begin
      case (reg_wdata[MD_HI:MD_LO])
        MD_CONT: next_seq = SEQ_RUN;
        MD_SINGLE: next_seq = SEQ_RUN;
        MD_IDLE: next_seq = SEQ_HOLD;
        MD_SLEEP: next_seq = SEQ_HOLD;
        default: next_seq = SEQ_CAL;
      endcase
    end else if (conv_done) begin
      case (seq)
        SEQ_CAL: next_seq = SEQ_HOLD;
        SEQ_RUN: next_seq = (op_mode_sel == MD_SINGLE) ? SEQ_HOLD : SEQ_RUN;
        default: next_seq = SEQ_HOLD;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      seq <= SEQ_RUN;
    end else begin
      seq <= next_seq;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      conv_cnt <= '0;
      first_result <= 1'b1;
    end else if (mode_wr || cfg_wr || seq == SEQ_HOLD) begin
      conv_cnt <= '0;
      first_result <= 1'b1;
    end else if (conv_done) begin
      conv_cnt <= '0;
      first_result <= 1'b0;
    end else if (tick) begin
      conv_cnt <= conv_cnt + 19'd1;
    end
  end

  assign filter_reset = (seq == SEQ_HOLD);
  assign sleep_powerdown = (seq == SEQ_HOLD) && (op_mode_sel == MD_SLEEP);
  assign chop_active = !chop_disable;
  assign cal_system = op_mode_sel[1];
  assign cal_full_scale = op_mode_sel[0];

  // mode register: host write, or self-move after single or calibration
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= MODE_RST;
    end else if (mode_wr) begin
      mode_reg <= reg_wdata[15:0];
    end else if (cal_store) begin
      mode_reg[MD_HI:MD_LO] <= MD_IDLE;
    end else if (conv_done && op_mode_sel == MD_SINGLE) begin
      mode_reg[MD_HI:MD_LO] <= MD_SLEEP;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= CFG_RST;
    end else if (cfg_wr) begin
      cfg_reg <= reg_wdata[15:0];
    end
  end

  // result, tag and error are captured together
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      result <= DATA_RST;
      result_channel_tag <= TAG_RST;
      status_err <= 1'b0;
    end else if (result_store) begin
      result <= clamped;
      result_channel_tag <= input_select;
      status_err <= conv_overrange || conv_underrange || missing_ref_flag;
    end
  end

  // a new result wins over a simultaneous data read
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      status_rdy_n <= 1'b1;
    end else if (result_store) begin
      status_rdy_n <= 1'b0;
    end else if (reg_rd && reg_addr == ADDR_DATA) begin
      status_rdy_n <= 1'b1;
    end
  end

  // pin is forced high for the whole calibration
  assign result_ready_n = (seq == SEQ_CAL) ? 1'b1 : status_rdy_n;

  // coefficient pairs; a calibration store beats a host write in one cycle
  for (genvar p = 0; p < 2; p++) begin : g_pair
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        ofs_coef[p] <= OFS_DEF;
        gain_coef[p] <= GAIN_DEF;
      end else if (cal_store && sel_pair == 2'(p + 2)) begin
        if (op_mode_sel[0]) begin
          gain_coef[p] <= 24'(conv_value) & DMASK;
        end else begin
          ofs_coef[p] <= 24'(conv_value) & DMASK;
        end
      end else if (coef_host_wr && sel_pair == 2'(p + 2)) begin
        if (reg_addr == ADDR_OFFSET) begin
          ofs_coef[p] <= reg_wdata & DMASK;
        end else if (reg_addr == ADDR_GAIN) begin
          gain_coef[p] <= reg_wdata & DMASK;
        end
      end
    end
  end

  // status fields assembled at their bit positions
  always_comb begin
    status_byte = 8'h00;
    status_byte[ST_RDY] = status_rdy_n;
    status_byte[ST_ERR] = status_err;
    status_byte[ST_MISSING_REF_FLAG] = missing_ref_flag;
    status_byte[ST_ZERO] = 1'b0;
    status_byte[ST_WIDE] = (DATA_W == 24);
    status_byte[2:0] = result_channel_tag;
  end

  // read port: data answers one cycle after the read strobe and then holds
  always_comb begin
    next_rdata = reg_rdata;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_STATUS: next_rdata = {16'h0000, status_byte};
        ADDR_MODE: next_rdata = {8'h00, mode_reg};
        ADDR_CONFIG: next_rdata = {8'h00, cfg_reg};
        ADDR_DATA: next_rdata = result;
        // low bit of the identity byte tells the result width
        ADDR_ID: next_rdata = {16'h0000, ID_UPPER, ID_FIXED, (DATA_W == 24)};
        ADDR_OFFSET: next_rdata = sel_pair[1] ? ofs_coef[sel_pair[0]] : OFS_DEF;
        ADDR_GAIN: next_rdata = sel_pair[1] ? gain_coef[sel_pair[0]] : GAIN_DEF;
        // unmapped addresses read zero
        default: next_rdata = 24'h000000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 24'h000000;
    end else begin
      reg_rdata <= next_rdata;
    end
  end
endmodule

/* File: test/badc_regs_asserts.sv */
// Purpose: port checks for badc_regs
// Assumes: one clk_sys domain, fields follow a write one cycle later
// Notes: attached by bind below
`timescale 1ns/100ps
module badc_regs_chk import badc_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [2:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [23:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [23:0] reg_rdata,
  input wire logic clk_pin_oe_n,
  input wire logic system_clock_tick,
  input wire logic result_ready_n,
  input wire logic filter_reset,
  input wire logic sleep_powerdown,
  input wire logic chop_active,
  input wire logic [3:0] rate_code,
  input wire logic burnout_src_en,
  input wire logic format_unipolar,
  input wire logic ref_detect_en,
  input wire logic [2:0] input_select,
  input wire logic force_unity_gain,
  input wire logic supply_div6_en,
  input wire logic cal_system,
  input wire logic cal_full_scale
);
  logic [23:0] wd_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wd_q <= 24'h0;
    end else begin
      wd_q <= reg_wdata;
    end
  end
  sequence md_wr;
    reg_wr && reg_addr == ADDR_MODE;
  endsequence
  sequence cfg_wr;
    reg_wr && reg_addr == ADDR_CONFIG;
  endsequence
  sequence md_is(logic [2:0] m);
    md_wr ##0 reg_wdata[MD_HI:MD_LO] == m;
  endsequence
  oe_pin_a: assert property (md_wr |=> clk_pin_oe_n == (wd_q[7:6] != CLKSEL_INT_OUT))
    else $error("clock pin enable wrong");
  rate_chop_a: assert property (md_wr |=> rate_code == wd_q[3:0] && chop_active == !wd_q[4])
    else $error("rate or chop wrong");
  cfg_fields_a: assert property (cfg_wr |=> burnout_src_en == wd_q[13]
    && format_unipolar == wd_q[12] && ref_detect_en == wd_q[5] && input_select == wd_q[2:0])
    else $error("config fields wrong");
  int_chan_a: assert property (cfg_wr |=> force_unity_gain == (wd_q[2:1] == 2'h3)
    && supply_div6_en == (wd_q[2:0] == CH_SUPPLY)) else $error("internal channel wrong");
  cont_run_a: assert property (md_is(MD_CONT) |=> !filter_reset && !sleep_powerdown)
    else $error("continuous mode wrong");
  idle_hold_a: assert property (md_is(MD_IDLE) |=> filter_reset && !sleep_powerdown)
    else $error("idle mode wrong");
  sleep_off_a: assert property (md_is(MD_SLEEP) |=> filter_reset && sleep_powerdown)
    else $error("sleep mode wrong");
  cal_start_a: assert property (md_wr ##0 reg_wdata[MD_HI] |=> result_ready_n
    && cal_system == wd_q[14] && cal_full_scale == wd_q[13]) else $error("calibration start");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  ready_set_a: assert property (reg_rd && reg_addr == ADDR_DATA |=> result_ready_n)
    else $error("ready not set by read");
  tick_pulse_a: assert property (system_clock_tick |=> !system_clock_tick)
    else $error("tick too long");
endmodule
bind badc_regs badc_regs_chk i_chk (.clk_sys, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
  .reg_rdata, .clk_pin_oe_n, .system_clock_tick, .result_ready_n, .filter_reset,
  .sleep_powerdown, .chop_active, .rate_code, .burnout_src_en, .format_unipolar,
  .ref_detect_en, .input_select, .force_unity_gain, .supply_div6_en, .cal_system,
  .cal_full_scale);

/* File: test/badc_front_model.sv */
// Purpose: front-end stand-in feeding results and the clock pin
// Assumes: bench sets result value and reference level
// Notes: external clock of 48 ns runs only while ext_on is high
`timescale 1ns/100ps
module badc_front_model (
  input wire logic ext_on,
  input wire logic [23:0] val,
  input wire logic low_ref,
  input wire logic clk_pin_o,
  input wire logic clk_pin_oe_n,
  output logic [23:0] conv_value,
  output logic conv_overrange,
  output logic conv_underrange,
  output logic ref_low,
  output logic clk_pin_i
);
  logic ext_clk = 1'b0;
  initial begin
    forever begin
      #24 ext_clk = ext_on & ~ext_clk;
    end
  end
  // pin level: device drive wins, else the external source, which stays low while ext_on is low
  assign clk_pin_i = !clk_pin_oe_n ? clk_pin_o : ext_clk;
  assign conv_value = val;
  assign conv_overrange = 1'b0;
  assign conv_underrange = 1'b0;
  assign ref_low = low_ref;
endmodule

/* File: test/tb_top.sv */
// Purpose: register-level test of badc_regs
// Assumes: TICK_DIV of 8 shortens conversions
// Notes: inputs change on the falling edge
`timescale 1ns/100ps
module tb_top import badc_pkg::*;;
  logic clk_sys = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic ext_on = 1'b0, low_ref = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [23:0] reg_wdata = 24'h0, val = 24'h3c5a17, q, reg_rdata, conv_value;
  logic conv_overrange, conv_underrange, ref_low, clk_pin_i, clk_pin_o, clk_pin_oe_n;
  logic system_clock_tick, result_ready_n, filter_reset, sleep_powerdown, chop_active;
  logic burnout_src_en, format_unipolar, ref_detect_en, force_unity_gain, use_internal_ref;
  logic supply_div6_en, cal_system, cal_full_scale;
  logic [3:0] rate_code;
  logic [2:0] input_select;
  int err_total = 0, checked = 0;
  badc_regs #(.DATA_W(24), .TICK_DIV(8)) i_dut (.clk_sys, .rst_n, .reg_addr, .reg_wr,
    .reg_wdata, .reg_rd, .reg_rdata, .conv_value, .conv_overrange, .conv_underrange, .ref_low,
    .clk_pin_i, .clk_pin_o, .clk_pin_oe_n, .system_clock_tick, .result_ready_n, .filter_reset,
    .sleep_powerdown, .chop_active, .rate_code, .burnout_src_en, .format_unipolar,
    .ref_detect_en, .input_select, .force_unity_gain, .use_internal_ref, .supply_div6_en,
    .cal_system, .cal_full_scale);
  badc_front_model i_front (.ext_on, .val, .low_ref, .clk_pin_o, .clk_pin_oe_n, .conv_value,
    .conv_overrange, .conv_underrange, .ref_low, .clk_pin_i);
  initial begin
    forever begin
      #2 clk_sys = ~clk_sys;
    end
  end
  task automatic report_and_stop();
    if (err_total == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [23:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    @(negedge clk_sys);
    q = reg_rdata;
  endtask
  task automatic rdc(input logic [2:0] a, input logic [23:0] e);
    rd(a);
    chk(q, e);
  endtask
  // cycles until the ready pin falls, against the expected conversion time
  task automatic meas(input int exp);
    int n;
    n = 0;
    while (result_ready_n !== 1'b0 && n < 40000) begin
      @(negedge clk_sys);
      n++;
    end
    chk(24'(n >= exp - 24 && n <= exp + 24), 24'h1);
  endtask
  task automatic wait_mode(input logic [23:0] e);
    int n;
    n = 0;
    q = 24'h0;
    while (q !== e && n < 400) begin
      repeat (64) @(negedge clk_sys);
      rd(ADDR_MODE);
      n++;
    end
    chk(q, e);
  endtask
  initial begin
    #380000;
    err_total++;
    report_and_stop();
  end
  initial begin
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
    chk(24'(result_ready_n), 24'h1);
    rdc(ADDR_MODE, 24'h00000a);
    rdc(ADDR_CONFIG, 24'h000710);
    rdc(ADDR_STATUS, 24'h000088);
    rdc(ADDR_OFFSET, OFFSET_RST);
    rdc(ADDR_GAIN, GAIN_RST);
    rdc(ADDR_ID, {16'h0, ID_UPPER, ID_FIXED, 1'b1});
    wr(3'h5, 24'hffffff);
    rdc(3'h5, 24'h0);
    wr(ADDR_DATA, 24'h123456);
    rdc(ADDR_DATA, 24'h0);
    wr(ADDR_OFFSET, 24'h123456);
    rdc(ADDR_OFFSET, OFFSET_RST);
    wr(ADDR_MODE, 24'h000010);
    meas(1151 * 8);
    rdc(ADDR_STATUS, 24'h000008);
    rdc(ADDR_DATA, val);
    rdc(ADDR_STATUS, 24'h000088);
    wr(ADDR_MODE, 24'h000000);
    meas(2 * 1151 * 8);
    rdc(ADDR_DATA, val);
    wr(ADDR_MODE, 24'h004010);
    chk(24'({filter_reset, sleep_powerdown}), 24'h2);
    wr(ADDR_OFFSET, 24'h123456);
    rdc(ADDR_OFFSET, 24'h123456);
    wr(ADDR_CONFIG, 24'h000711);
    rdc(ADDR_OFFSET, OFFSET_RST);
    wr(ADDR_GAIN, 24'h0abcde);
    rdc(ADDR_GAIN, 24'h0abcde);
    wr(ADDR_CONFIG, 24'h000713);
    rdc(ADDR_OFFSET, 24'h123456);
    rdc(ADDR_GAIN, GAIN_RST);
    wr(ADDR_CONFIG, 24'h000716);
    wr(ADDR_OFFSET, 24'h777777);
    rdc(ADDR_OFFSET, OFFSET_RST);
    chk(24'({force_unity_gain, use_internal_ref, supply_div6_en}), 24'h6);
    wr(ADDR_CONFIG, 24'h000717);
    chk(24'({force_unity_gain, use_internal_ref, supply_div6_en}), 24'h7);
    wr(ADDR_CONFIG, 24'h000711);
    for (int k = 4; k < 8; k++) begin
      val = 24'(k) * 24'h102030;
      wr(ADDR_MODE, {8'h0, 3'(k), 13'h0010});
      chk(24'(result_ready_n), 24'h1);
      wait_mode(24'h004010);
      rdc(k[0] ? ADDR_GAIN : ADDR_OFFSET, val);
    end
    wr(ADDR_CONFIG, 24'h003731);
    chk(24'({burnout_src_en, format_unipolar, ref_detect_en}), 24'h7);
    wr(ADDR_MODE, 24'h006050);
    chk(24'(sleep_powerdown), 24'h1);
    chk(24'(clk_pin_oe_n), 24'h0);
    q = 24'(clk_pin_o);
    repeat (4) @(negedge clk_sys);
    chk(24'(clk_pin_o), 24'(!q[0]));
    ext_on = 1'b1;
    low_ref = 1'b1;
    wr(ADDR_MODE, 24'h002090);
    chk(24'(clk_pin_oe_n), 24'h1);
    meas(1151 * 12);
    rdc(ADDR_STATUS, 24'h000069);
    rdc(ADDR_DATA, 24'hffffff);
    rdc(ADDR_MODE, 24'h006090);
    chk(24'(sleep_powerdown), 24'h1);
    report_and_stop();
  end
endmodule
